// [hdl/tcp_timer.sv]
// Behaviour
// - channel value readable, writable, cleared by reset
// - capture read latches both bytes until pair
// - compare/PWM value writes paired before transfer
// - clock select resets off; 01 selects bus
// - debug halt pauses counting
// - center select makes all channels center PWM
// - up mode wraps terminal count to zero
// - up/down turns at modulus and zero
// - overflow flag with enable gives level request
// - overflow flag set on wrap or upper turn
// - counter read latches both bytes coherently
// - counter write resets count and read latch
// - capture edge copies count, sets flag
// - compare match drives pin, sets flag
// - edge PWM overflow activates, match deactivates
// - zero gives 0%, above modulus 100%
// - edge PWM value loads at zero count
// - edge select 00 frees pin; mode decode
// - compare edge select: none, toggle, clear, set
// - center match up inactive, down active
// - center buffers load at the upper turn
//
// Chosen here: the APB interface to the registers and the register offsets.
`include "tcp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tcp_timer
	import tcp_pkg::*;
#(
	parameter int NUM_CH = 2
)
(
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              dbgHalt,
	input  wire logic              fixedClkIn,
	input  wire logic              extClkIn,
	input  wire logic [NUM_CH-1:0] chPinIn,
	output logic      [NUM_CH-1:0] chPinOut,
	output logic      [NUM_CH-1:0] chPinOe_n,
	output logic                   overflowIrq
);

	logic [1:0]    rstSync_reg;
	logic          rstSys_n;
	logic          busPrep;
	logic          busDone;
	logic          rdPrep;
	logic          wrDone;
	logic          selCtrl;
	logic          selCntHi;
	logic          selCntLo;
	logic          selModHi;
	logic          selModLo;
	logic [7:0]    rdData;
	logic          rdHit;
	tcpTimerCtrl_t timerCtrl_reg;
	logic          ovfFlag_reg;
	logic          ovfArm_reg;
	logic [2:0]    fixSync_reg;
	logic [2:0]    extSync_reg;
	logic          tickSel;
	logic          tick;
	logic          clkOff;
	logic [15:0]   count_reg;
	tcpDir_t       dir_reg;
	logic [15:0]   modulus_reg;
	logic [15:0]   modBuf_reg;
	logic [1:0]    modGot_reg;
	logic [15:0]   terminal;
	logic          ovfEvent;
	logic          reloadPoint;
	logic          cntWr;
	logic [15:0]   cntLatch_reg;
	logic          cntLatched_reg;
	logic [1:0]    cntGot_reg;
	logic [15:0]   cntShown;
	logic [1:0]    cntRdBit;
	logic [7:0]    chCtrlByte [NUM_CH];
	logic [15:0]   chShown    [NUM_CH];

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rstSync_reg <= 2'b00;
		else
			rstSync_reg <= {rstSync_reg[0], 1'b1};
	end
	assign rstSys_n = rstSync_reg[1];

	// Bus phases: prep cycle makes read data, done edge commits writes
	assign busPrep  = psel & penable & ~pready;
	assign busDone  = psel & penable & pready;
	assign rdPrep   = busPrep & ~pwrite;
	assign wrDone   = busDone & pwrite;
	assign selCtrl  = (paddr == `TCP_OFS_CTRL);
	assign selCntHi = (paddr == `TCP_OFS_CNT_HI);
	assign selCntLo = (paddr == `TCP_OFS_CNT_LO);
	assign selModHi = (paddr == `TCP_OFS_MOD_HI);
	assign selModLo = (paddr == `TCP_OFS_MOD_LO);
	assign cntWr    = wrDone & (selCntHi | selCntLo);
	assign cntRdBit = {selCntHi, selCntLo};

	// Read multiplexer
	always_comb
	begin
		rdData = 8'h00;
		rdHit  = 1'b1;
		if (selCtrl)
			rdData = {ovfFlag_reg, timerCtrl_reg, 3'b000};
		else if (selCntHi)
			rdData = cntShown[15:8];
		else if (selCntLo)
			rdData = cntShown[7:0];
		else if (selModHi)
			rdData = modulus_reg[15:8];
		else if (selModLo)
			rdData = modulus_reg[7:0];
		else
			rdHit = 1'b0;
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (paddr[7:4] == 4'(`TCP_CH_PAGE + i))
			begin
				rdHit = (paddr[3:0] == `TCP_SUB_CTRL) || (paddr[3:0] == `TCP_SUB_VAL_HI)
					|| (paddr[3:0] == `TCP_SUB_VAL_LO);
				if (paddr[3:0] == `TCP_SUB_CTRL)
					rdData = chCtrlByte[i];
				else if (paddr[3:0] == `TCP_SUB_VAL_HI)
					rdData = chShown[i][15:8];
				else if (paddr[3:0] == `TCP_SUB_VAL_LO)
					rdData = chShown[i][7:0];
			end
		end
	end

	// APB answer: one wait state, unmapped addresses flag an error
	always_ff @(posedge clk_sys or negedge rstSys_n)
	begin
		if (!rstSys_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= busPrep;
			pslverr <= busPrep & ~rdHit;
			if (rdPrep)
				prdata <= {24'h00_0000, rdHit ? rdData : 8'h00};
		end
	end

	// Timer control register and cancelling of the modulus pair
	always_ff @(posedge clk_sys or negedge rstSys_n)
	begin
		if (!rstSys_n)
			timerCtrl_reg <= '{overflowIrqEnable: 1'b0, centerAlignSelect: 1'b0,
				clockSelect: `TCP_CLK_OFF};
		else if (wrDone && selCtrl)
			timerCtrl_reg <= '{overflowIrqEnable: pwdata[`TCP_BIT_IE],
				centerAlignSelect: pwdata[`TCP_BIT_CPWM],
				clockSelect: pwdata[`TCP_BIT_CLK_HI:`TCP_BIT_CLK_LO]};
	end

	// Overflow flag: read-while-set arms, write 0 clears, new event wins
	always_ff @(posedge clk_sys or negedge rstSys_n)
	begin
		if (!rstSys_n)
		begin
			ovfFlag_reg <= 1'b0;
			ovfArm_reg  <= 1'b0;
		end
		else if (ovfEvent)
		begin
			ovfFlag_reg <= 1'b1;
			ovfArm_reg  <= 1'b0;
		end
		else if (wrDone && selCtrl && !pwdata[`TCP_BIT_FLAG] && ovfArm_reg)
		begin
			ovfFlag_reg <= 1'b0;
			ovfArm_reg  <= 1'b0;
		end
		else if (rdPrep && selCtrl && ovfFlag_reg)
			ovfArm_reg <= 1'b1;
	end

	// Level request while flag and enable are both set
	always_ff @(posedge clk_sys or negedge rstSys_n)
	begin
		if (!rstSys_n)
			overflowIrq <= 1'b0;
		else
			overflowIrq <= ovfFlag_reg & timerCtrl_reg.overflowIrqEnable;
	end

	// Synchronisers for the fixed and external clock inputs
	always_ff @(posedge clk_sys or negedge rstSys_n)
	begin
		if (!rstSys_n)
		begin
			fixSync_reg <= 3'b000;
			extSync_reg <= 3'b000;
		end
		else
		begin
			fixSync_reg <= {fixSync_reg[1:0], fixedClkIn};
			extSync_reg <= {extSync_reg[1:0], extClkIn};
		end
	end

	// Counting enable from the selected source, paused in debug halt
	always_comb
	begin
		case (timerCtrl_reg.clockSelect)
			`TCP_CLK_BUS:   tickSel = 1'b1;
			`TCP_CLK_FIXED: tickSel = fixSync_reg[1] & ~fixSync_reg[2];
			`TCP_CLK_EXT:   tickSel = extSync_reg[1] & ~extSync_reg[2];
			default:        tickSel = 1'b0;
		endcase
	end
	assign clkOff   = (timerCtrl_reg.clockSelect == `TCP_CLK_OFF);
	assign tick     = tickSel & ~dbgHalt;
	assign terminal = (modulus_reg == `TCP_CNT_ZERO) ? `TCP_CNT_MAX : modulus_reg;

	// Overflow: wrap in up mode, upper turn in up/down mode
	assign ovfEvent = tick & (timerCtrl_reg.centerAlignSelect
		? (dir_reg == DIR_UP) && (count_reg == modulus_reg)
		: (count_reg == terminal));
	assign reloadPoint = ovfEvent | clkOff;

	// Main counter
	always_ff @(posedge clk_sys or negedge rstSys_n)
	begin
		if (!rstSys_n)
		begin
			count_reg <= `TCP_CNT_ZERO;
			dir_reg   <= DIR_UP;
		end
		else if (cntWr)
		begin
			count_reg <= `TCP_CNT_ZERO;
			dir_reg   <= DIR_UP;
		end
		else if (tick)
		begin
			if (!timerCtrl_reg.centerAlignSelect)
			begin
				dir_reg <= DIR_UP;
				if (count_reg == terminal)
					count_reg <= `TCP_CNT_ZERO;
				else
					count_reg <= count_reg + `TCP_CNT_ONE;
			end
			else
			begin
				case (dir_reg)
					DIR_UP:
					begin
						if (count_reg == modulus_reg)
						begin
							dir_reg   <= DIR_DOWN;
							count_reg <= count_reg - `TCP_CNT_ONE;
						end
						else
							count_reg <= count_reg + `TCP_CNT_ONE;
					end
					DIR_DOWN:
					begin
						if (count_reg == `TCP_CNT_ZERO)
						begin
							dir_reg   <= DIR_UP;
							count_reg <= count_reg + `TCP_CNT_ONE;
						end
						else
							count_reg <= count_reg - `TCP_CNT_ONE;
					end
					default:
						dir_reg <= DIR_UP;
				endcase
			end
		end
	end

	// Modulus buffer: pair of bytes, moved at the reload point
	always_ff @(posedge clk_sys or negedge rstSys_n)
	begin
		if (!rstSys_n)
		begin
			modulus_reg <= `TCP_CNT_ZERO;
			modBuf_reg  <= `TCP_CNT_ZERO;
			modGot_reg  <= 2'b00;
		end
		else if (wrDone && selCtrl)
			modGot_reg <= 2'b00;
		else if (wrDone && selModHi)
		begin
			modBuf_reg[15:8] <= pwdata[7:0];
			modGot_reg[1]    <= 1'b1;
		end
		else if (wrDone && selModLo)
		begin
			modBuf_reg[7:0] <= pwdata[7:0];
			modGot_reg[0]   <= 1'b1;
		end
		else if (modGot_reg == 2'b11 && reloadPoint)
		begin
			modulus_reg <= modBuf_reg;
			modGot_reg  <= 2'b00;
		end
	end

	// Counter read coherency latch
	always_ff @(posedge clk_sys or negedge rstSys_n)
	begin
		if (!rstSys_n)
		begin
			cntLatch_reg   <= `TCP_CNT_ZERO;
			cntLatched_reg <= 1'b0;
			cntGot_reg     <= 2'b00;
		end
		else if (cntWr)
		begin
			cntLatched_reg <= 1'b0;
			cntGot_reg     <= 2'b00;
		end
		else if (rdPrep && (selCntHi || selCntLo))
		begin
			if (!cntLatched_reg)
			begin
				cntLatch_reg   <= count_reg;
				cntLatched_reg <= 1'b1;
				cntGot_reg     <= cntRdBit;
			end
			else if ((cntGot_reg | cntRdBit) == 2'b11)
			begin
				cntLatched_reg <= 1'b0;
				cntGot_reg     <= 2'b00;
			end
			else
				cntGot_reg <= cntGot_reg | cntRdBit;
		end
	end
	assign cntShown = cntLatched_reg ? cntLatch_reg : count_reg;

	// Channels
	for (genvar n = 0; n < NUM_CH; n++)
	begin : gCh
		tcpChanCtrl_t ctrl_reg;
		logic         flag_reg;
		logic         arm_reg;
		logic [15:0]  val_reg;
		logic [15:0]  buf_reg;
		logic [1:0]   wrGot_reg;
		logic [15:0]  latch_reg;
		logic         latched_reg;
		logic [1:0]   rdGot_reg;
		logic [2:0]   pinSync_reg;
		logic         hit;
		logic         selC;
		logic         selH;
		logic         selL;
		logic [1:0]   rdBit;
		logic         pinUsed;
		logic         capMode;
		logic         cmpMode;
		logic         epwmMode;
		logic         cpwmMode;
		logic         match;
		logic         capEvt;
		logic         activeLvl;
		logic         pinRise;
		logic         pinFall;
		logic [15:0]  loadVal;

		assign hit     = (paddr[7:4] == 4'(`TCP_CH_PAGE + n));
		assign selC    = hit && (paddr[3:0] == `TCP_SUB_CTRL);
		assign selH    = hit && (paddr[3:0] == `TCP_SUB_VAL_HI);
		assign selL    = hit && (paddr[3:0] == `TCP_SUB_VAL_LO);
		assign rdBit   = {selH, selL};
		// Mode decode
		assign pinUsed  = (ctrl_reg.polaritySelect != `TCP_POL_NONE);
		assign cpwmMode = timerCtrl_reg.centerAlignSelect;
		assign capMode  = !cpwmMode && !ctrl_reg.modeSelectHigh && !ctrl_reg.modeSelectLow;
		assign cmpMode  = !cpwmMode && !ctrl_reg.modeSelectHigh && ctrl_reg.modeSelectLow;
		assign epwmMode = !cpwmMode && ctrl_reg.modeSelectHigh;
		assign match    = tick && (count_reg == val_reg);
		assign pinRise  = pinSync_reg[1] & ~pinSync_reg[2];
		assign pinFall  = ~pinSync_reg[1] & pinSync_reg[2];
		assign capEvt   = capMode && (
			(ctrl_reg.polaritySelect == `TCP_POL_RISE && pinRise) ||
			(ctrl_reg.polaritySelect == `TCP_POL_FALL && pinFall) ||
			(ctrl_reg.polaritySelect == `TCP_POL_BOTH && (pinRise || pinFall)));
		assign activeLvl = ~ctrl_reg.polaritySelect[0];
		// Value that governs the period starting at the wrap, pending pair included
		assign loadVal   = (wrGot_reg == 2'b11) ? buf_reg : val_reg;
		assign chCtrlByte[n] = {flag_reg, ctrl_reg, 2'b00};
		assign chShown[n]    = latched_reg ? latch_reg : val_reg;

		// Pin synchroniser
		always_ff @(posedge clk_sys or negedge rstSys_n)
		begin
			if (!rstSys_n)
				pinSync_reg <= 3'b111;                // Pull-up level, no false edge after reset
			else
				pinSync_reg <= {pinSync_reg[1:0], chPinIn[n]};
		end

		// Channel control register
		always_ff @(posedge clk_sys or negedge rstSys_n)
		begin
			if (!rstSys_n)
				ctrl_reg <= '{chIrqEnable: 1'b0, modeSelectHigh: 1'b0,
					modeSelectLow: 1'b0, polaritySelect: `TCP_POL_NONE};
			else if (wrDone && selC)
				ctrl_reg <= '{chIrqEnable: pwdata[`TCP_BIT_IE],
					modeSelectHigh: pwdata[`TCP_BIT_MSH],
					modeSelectLow: pwdata[`TCP_BIT_MSL],
					polaritySelect: pwdata[`TCP_BIT_POL_HI:`TCP_BIT_POL_LO]};
		end

		// Event flag with two-step clear; a new event wins
		always_ff @(posedge clk_sys or negedge rstSys_n)
		begin
			if (!rstSys_n)
			begin
				flag_reg <= 1'b0;
				arm_reg  <= 1'b0;
			end
			else if (capEvt || (match && !capMode))
			begin
				flag_reg <= 1'b1;
				arm_reg  <= 1'b0;
			end
			else if (wrDone && selC && !pwdata[`TCP_BIT_FLAG] && arm_reg)
			begin
				flag_reg <= 1'b0;
				arm_reg  <= 1'b0;
			end
			else if (rdPrep && selC && flag_reg)
				arm_reg <= 1'b1;
		end

		// Value register with write pairing and capture
		always_ff @(posedge clk_sys or negedge rstSys_n)
		begin
			if (!rstSys_n)
			begin
				val_reg   <= `TCP_CNT_ZERO;
				buf_reg   <= `TCP_CNT_ZERO;
				wrGot_reg <= 2'b00;
			end
			else
			begin
				if (capEvt)
					val_reg <= count_reg;
				else if (wrGot_reg == 2'b11 && (capMode || cmpMode || reloadPoint))
					val_reg <= buf_reg;
				if (wrDone && selC)
					wrGot_reg <= 2'b00;
				else if (wrDone && selH)
				begin
					buf_reg[15:8] <= pwdata[7:0];
					wrGot_reg[1]  <= 1'b1;
				end
				else if (wrDone && selL)
				begin
					buf_reg[7:0] <= pwdata[7:0];
					wrGot_reg[0] <= 1'b1;
				end
				else if (wrGot_reg == 2'b11 && !capEvt
					&& (capMode || cmpMode || reloadPoint))
					wrGot_reg <= 2'b00;
			end
		end

		// Capture-mode read latch
		always_ff @(posedge clk_sys or negedge rstSys_n)
		begin
			if (!rstSys_n)
			begin
				latch_reg   <= `TCP_CNT_ZERO;
				latched_reg <= 1'b0;
				rdGot_reg   <= 2'b00;
			end
			else if ((wrDone && selC) || !capMode)
			begin
				latched_reg <= 1'b0;
				rdGot_reg   <= 2'b00;
			end
			else if (rdPrep && (selH || selL))
			begin
				if (!latched_reg)
				begin
					latch_reg   <= val_reg;
					latched_reg <= 1'b1;
					rdGot_reg   <= rdBit;
				end
				else if ((rdGot_reg | rdBit) == 2'b11)
				begin
					latched_reg <= 1'b0;
					rdGot_reg   <= 2'b00;
				end
				else
					rdGot_reg <= rdGot_reg | rdBit;
			end
		end

		// Pin driver for compare and PWM
		always_ff @(posedge clk_sys or negedge rstSys_n)
		begin
			if (!rstSys_n)
			begin
				chPinOut[n]  <= 1'b0;
				chPinOe_n[n] <= 1'b1;
			end
			else
			begin
				chPinOe_n[n] <= ~(pinUsed && !capMode);
				if (cmpMode && match)
				begin
					case (ctrl_reg.polaritySelect)
						`TCP_POL_RISE: chPinOut[n] <= ~chPinOut[n];
						`TCP_POL_FALL: chPinOut[n] <= 1'b0;
						`TCP_POL_BOTH: chPinOut[n] <= 1'b1;
						default:       chPinOut[n] <= chPinOut[n];
					endcase
				end
				else if (epwmMode)
				begin
					if (ovfEvent)
						chPinOut[n] <= (loadVal != `TCP_CNT_ZERO) ? activeLvl : ~activeLvl;
					else if (match || val_reg == `TCP_CNT_ZERO)
						chPinOut[n] <= ~activeLvl;
				end
				else if (cpwmMode && match && val_reg != `TCP_CNT_ZERO)
					chPinOut[n] <= (dir_reg == DIR_UP) ? ~activeLvl : activeLvl;
			end
		end

		AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rstSys_n)
			capEvt |=> (val_reg == $past(count_reg)) && flag_reg)
			else $error("capture did not copy count and set flag");
		AST_PWM_ZERO: assert property (@(posedge clk_sys) disable iff (!rstSys_n)
			(epwmMode && val_reg == `TCP_CNT_ZERO && !cmpMode) [*2] |-> chPinOut[n] == ~activeLvl)
			else $error("zero duty pwm output not inactive");
	end

	// Assertions on the counter and overflow logic
	default clocking cbSys @(posedge clk_sys); endclocking
	default disable iff (!rstSys_n);

	sequence seqTurn;
		tick && timerCtrl_reg.centerAlignSelect && dir_reg == DIR_UP
			&& count_reg == modulus_reg && !cntWr;
	endsequence
	sequence seqFirstCntRead;
		rdPrep && selCntHi && !cntLatched_reg && !cntWr;
	endsequence

	AST_UP_WRAP: assert property (tick && !timerCtrl_reg.centerAlignSelect
		&& count_reg == terminal && !cntWr |=> count_reg == `TCP_CNT_ZERO)
		else $error("up counter did not wrap to zero");
	AST_UP_STEP: assert property (tick && !timerCtrl_reg.centerAlignSelect
		&& count_reg != terminal && !cntWr |=> count_reg == $past(count_reg) + `TCP_CNT_ONE)
		else $error("up counter did not step by one");
	AST_TURN: assert property (seqTurn |=> dir_reg == DIR_DOWN
		&& count_reg == $past(count_reg) - `TCP_CNT_ONE && ovfFlag_reg)
		else $error("center counter did not turn at modulus");
	AST_OVF_SET: assert property (ovfEvent |=> ovfFlag_reg)
		else $error("overflow event did not set flag");
	AST_IRQ_MASK: assert property (!timerCtrl_reg.overflowIrqEnable |=> !overflowIrq)
		else $error("overflow request without enable");
	AST_IRQ_LEVEL: assert property (ovfFlag_reg && timerCtrl_reg.overflowIrqEnable
		[*2] |-> overflowIrq)
		else $error("overflow request not held");
	AST_CLK_OFF: assert property (clkOff && !cntWr |=> $stable(count_reg))
		else $error("counter moved with no clock selected");
	AST_HALT: assert property (dbgHalt && !cntWr |=> $stable(count_reg))
		else $error("counter moved in debug halt");
	AST_CNT_LATCH: assert property (seqFirstCntRead |=> cntLatched_reg
		&& cntLatch_reg == $past(count_reg))
		else $error("counter read did not latch both bytes");
	AST_CNT_RESET: assert property (cntWr |=> count_reg == `TCP_CNT_ZERO
		&& !cntLatched_reg && cntGot_reg == 2'b00)
		else $error("counter write did not reset count and latch");

endmodule : tcp_timer
`default_nettype wire

// [hdl/tcp_defs.svh]
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// Register offsets, byte addresses on the APB bus
`define TCP_OFS_CTRL    8'h00
`define TCP_OFS_CNT_HI  8'h04
`define TCP_OFS_CNT_LO  8'h08
`define TCP_OFS_MOD_HI  8'h0C
`define TCP_OFS_MOD_LO  8'h10
// Channel n occupies page (TCP_CH_PAGE + n), 16 bytes each
`define TCP_CH_PAGE     4'h2
`define TCP_SUB_CTRL    4'h0
`define TCP_SUB_VAL_HI  4'h4
`define TCP_SUB_VAL_LO  4'h8

// Bit positions inside control registers
`define TCP_BIT_FLAG    7
`define TCP_BIT_IE      6
`define TCP_BIT_CPWM    5
`define TCP_BIT_CLK_HI  4
`define TCP_BIT_CLK_LO  3
`define TCP_BIT_MSH     5
`define TCP_BIT_MSL     4
`define TCP_BIT_POL_HI  3
`define TCP_BIT_POL_LO  2

// Clock select codes
`define TCP_CLK_OFF     2'b00
`define TCP_CLK_BUS     2'b01
`define TCP_CLK_FIXED   2'b10
`define TCP_CLK_EXT     2'b11

// Edge/level select codes
`define TCP_POL_NONE    2'b00
`define TCP_POL_RISE    2'b01
`define TCP_POL_FALL    2'b10
`define TCP_POL_BOTH    2'b11

// Counter values
`define TCP_CNT_ZERO    16'h0000
`define TCP_CNT_MAX     16'hFFFF
`define TCP_CNT_ONE     16'h0001

`endif

// [hdl/tcp_pkg.sv]
package tcp_pkg;
	// Direction of the main counter, one-hot
	typedef enum logic [1:0]
	{
		DIR_UP   = 2'b01,
		DIR_DOWN = 2'b10
	} tcpDir_t;

	// Software-written timer control fields
	typedef struct packed
	{
		logic       overflowIrqEnable;
		logic       centerAlignSelect;
		logic [1:0] clockSelect;
	} tcpTimerCtrl_t;

	// Software-written channel control fields
	typedef struct packed
	{
		logic       chIrqEnable;
		logic       modeSelectHigh;
		logic       modeSelectLow;
		logic [1:0] polaritySelect;
	} tcpChanCtrl_t;
endpackage : tcp_pkg

// [verif/tcp_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none

// Far side of the channel pins: pull-up, bench driver, or timer drive
module tcp_pin_model
#(
	parameter int NUM_CH = 2
)
(
	input  wire logic [NUM_CH-1:0] chPinOut,
	input  wire logic [NUM_CH-1:0] chPinOe_n,
	input  wire logic [NUM_CH-1:0] extDrive,
	input  wire logic [NUM_CH-1:0] extEn,
	output logic      [NUM_CH-1:0] pinLevel
);
	// A released pin floats up to the pull-up level
	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			pinLevel[i] = !chPinOe_n[i] ? chPinOut[i] : (extEn[i] ? extDrive[i] : 1'b1);
		end
	end
endmodule : tcp_pin_model

`default_nettype wire

// [verif/timer_capture_compare_pwm_bench.sv]
`include "tcp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module timer_capture_compare_pwm_bench;
	localparam logic [7:0] C0 = {`TCP_CH_PAGE, 4'h0};
	localparam logic [7:0] C1 = C0 + 8'h10;
	logic        clk_sys, rst_n, psel, penable, pwrite, dbgHalt;
	logic [7:0]  paddr, rd, a, h;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, overflowIrq, err, extClk;
	logic [1:0]  chPinIn, chPinOut, chPinOe_n, extDrive, extEn;
	logic [7:0]  pc[4] = '{8'h28, 8'h24, 8'h28, 8'h28};
	logic [7:0]  pv[4] = '{8'h10, 8'h10, 8'h00, 8'h50};
	logic [7:0]  pe[4] = '{8'd17, 8'd47, 8'd0, 8'd64};
	int          errors, comparisons, cycles, ones;

	tcp_timer #(.NUM_CH(2)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dbgHalt(dbgHalt),
		.fixedClkIn(extClk), .extClkIn(extClk), .chPinIn(chPinIn), .chPinOut(chPinOut),
		.chPinOe_n(chPinOe_n), .overflowIrq(overflowIrq));
	tcp_pin_model #(.NUM_CH(2)) pins (.chPinOut(chPinOut), .chPinOe_n(chPinOe_n),
		.extDrive(extDrive), .extEn(extEn), .pinLevel(chPinIn));

	// Clock and hang guard
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			stop_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; waits for pready, then releases
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n == 20)
			errors++;
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		apb(1'b1, ad, d);
	endtask : wr

	task automatic rdx(input logic [7:0] ad, input logic [7:0] exp);
		apb(1'b0, ad, 8'h00);
		check(rd, exp);
	endtask : rdx

	// Counts high cycles of channel 0 over one 64-cycle period
	task automatic duty(input logic [7:0] exp);
		repeat (70) @(posedge clk_sys);
		ones = 0;
		repeat (64)
		begin
			@(posedge clk_sys);
			ones += chPinOut[0];
		end
		check(8'(ones), exp);
	endtask : duty

	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// Main sequence
	initial
	begin
		{rst_n, psel, penable, pwrite, dbgHalt, extDrive, extEn, extClk} = '0;
		{paddr, pwdata, errors, comparisons, cycles} = '0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rdx(`TCP_OFS_CTRL, 8'h00);
		rdx(C0 + `TCP_SUB_VAL_HI, 8'h00);
		rdx(C0 + `TCP_SUB_VAL_LO, 8'h00);
		rdx(8'hFC, 8'h00);
		check({7'h00, err}, 8'h01);
		// Overflow flag, request and two-step clear
		wr(`TCP_OFS_MOD_LO, 8'h40);
		wr(`TCP_OFS_MOD_HI, 8'h00);
		wr(`TCP_OFS_CTRL, 8'h48);
		repeat (80) @(posedge clk_sys);
		check({7'h00, overflowIrq}, 8'h01);
		rdx(`TCP_OFS_CTRL, 8'hC8);
		wr(`TCP_OFS_CTRL, 8'h40);
		rdx(`TCP_OFS_CTRL, 8'h40);
		check({7'h00, overflowIrq}, 8'h00);
		// Manual reset and coherent count reads
		wr(`TCP_OFS_CNT_HI, 8'h5A);
		rdx(`TCP_OFS_CNT_HI, 8'h00);
		rdx(`TCP_OFS_CNT_LO, 8'h00);
		wr(`TCP_OFS_CTRL, 8'h08);
		rdx(`TCP_OFS_CNT_LO, 8'h02);
		a = rd;
		repeat (10) @(posedge clk_sys);
		rdx(`TCP_OFS_CNT_LO, a);
		rdx(`TCP_OFS_CNT_HI, 8'h00);
		rdx(`TCP_OFS_CNT_LO, 8'h18);
		check({7'h00, rd === a}, 8'h00);
		dbgHalt <= 1'b1;
		rdx(`TCP_OFS_CNT_HI, 8'h00);
		rdx(`TCP_OFS_CNT_LO, 8'h1B);
		a = rd;
		repeat (20) @(posedge clk_sys);
		rdx(`TCP_OFS_CNT_HI, 8'h00);
		rdx(`TCP_OFS_CNT_LO, a);
		rdx(`TCP_OFS_CNT_HI, 8'h00);
		dbgHalt <= 1'b0;
		// Edge PWM on channel 0, compare-set on channel 1
		wr(`TCP_OFS_CTRL, 8'h00);
		wr(`TCP_OFS_MOD_LO, 8'h3F);
		wr(`TCP_OFS_MOD_HI, 8'h00);
		wr(`TCP_OFS_CTRL, 8'h08);
		wr(C1, 8'h1C);
		wr(C1 + `TCP_SUB_VAL_LO, 8'h10);
		wr(C1 + `TCP_SUB_VAL_HI, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(C0, pc[i]);
			wr(C0 + `TCP_SUB_VAL_HI, 8'h00);
			wr(C0 + `TCP_SUB_VAL_LO, pv[i]);
			duty(pe[i]);
		end
		check({6'h00, chPinOe_n[1], chPinOut[1]}, 8'h01);
		rdx(C1, 8'h9C);
		// Rising-edge capture with the counter stopped
		wr(C1, 8'h04);
		extEn[1] <= 1'b1;
		wr(`TCP_OFS_CTRL, 8'h00);
		rdx(C1 + `TCP_SUB_VAL_LO, 8'h10);
		rdx(C1 + `TCP_SUB_VAL_HI, 8'h00);
		wr(`TCP_OFS_CNT_LO, 8'h00);
		rdx(`TCP_OFS_CNT_LO, 8'h00);
		a = rd;
		rdx(`TCP_OFS_CNT_HI, 8'h00);
		h = rd;
		extDrive[1] <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rdx(C1 + `TCP_SUB_VAL_HI, h);
		rdx(C1 + `TCP_SUB_VAL_LO, a);
		rdx(C1, 8'h84);
		// External then fixed clock: four rising edges each, one eighth of clk_sys
		for (int s = 0; s < 2; s++)
		begin
			wr(`TCP_OFS_CTRL, (s == 0) ? 8'h18 : 8'h10);
			repeat (8)
			begin
				repeat (4) @(posedge clk_sys);
				extClk <= ~extClk;
			end
			repeat (4) @(posedge clk_sys);
			rdx(`TCP_OFS_CNT_LO, 8'(4 * s + 4));
			rdx(`TCP_OFS_CNT_HI, 8'h00);
		end
		wr(`TCP_OFS_CTRL, 8'h00);
		// Center-aligned PWM, period twice the modulus
		wr(`TCP_OFS_MOD_LO, 8'h20);
		wr(`TCP_OFS_MOD_HI, 8'h00);
		wr(C0, 8'h08);
		wr(C0 + `TCP_SUB_VAL_LO, 8'h08);
		wr(C0 + `TCP_SUB_VAL_HI, 8'h00);
		wr(`TCP_OFS_CTRL, 8'h28);
		duty(8'd16);
		stop_test();
	end
endmodule : timer_capture_compare_pwm_bench

`default_nettype wire
